// >>> sadc_defs.svh
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ****************************************
// clocking and filter figures
// ****************************************
`define SADC_DIV_256 4
`define SADC_DIV_384 6
`define SADC_MOD_OSR 64
`define SADC_WORD_W 16
`define SADC_CIC_ORDER 4
`define SADC_GROUP_DELAY_FS 36
`define SADC_CAL_FRAMES 8192
`define SADC_CAL_AVG_LOG2 8

// ****************************************
// register map, byte addresses
// ****************************************
`define SADC_ADDR_W 8
`define SADC_REG_CTRL 8'h00
`define SADC_REG_STATUS 8'h04
`define SADC_REG_LEFT 8'h08
`define SADC_REG_RIGHT 8'h0C
`define SADC_CTRL_RECAL_BIT 0
`define SADC_CTRL_OFS_EN_BIT 1
`define SADC_CTRL_OFS_EN_RESET 1'b1
`define SADC_STAT_ACTIVE_BIT 0
`define SADC_STAT_CAL_BUSY_BIT 1
`define SADC_STAT_CAL_DONE_BIT 2

`endif

// >>> sadc_pkg.sv
package sadc_pkg;

   typedef struct packed {
      logic ratio_384;
      logic slave_mode;
      logic read_edge_select;
   } sadc_mode_t;

   typedef struct packed {
      logic left;
      logic right;
   } sadc_mod_bits_t;

   typedef struct packed {
      logic bit_clock;
      logic channel_frame_clock;
   } sadc_slave_clk_t;

   typedef struct packed {
      logic bit_clock;
      logic channel_frame_clock;
      logic serial_sample_output;
   } sadc_ser_out_t;

   typedef enum logic [1:0] {
      SADC_ST_WAIT_FALL,
      SADC_ST_WAIT_RISE,
      SADC_ST_RUN
   } sadc_start_t;

   typedef enum logic {
      SADC_CAL_RUN,
      SADC_CAL_DONE
   } sadc_cal_t;

endpackage : sadc_pkg

// >>> sadc_cic.sv
`timescale 1ns/10ps
`include "sadc_defs.svh"

module sadc_cic #(
   parameter int ORDER = `SADC_CIC_ORDER,
   parameter int OSR = `SADC_MOD_OSR,
   parameter int WORD_W = `SADC_WORD_W,
   parameter int PAD = 34
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_mod_tick,
   input wire logic i_mod_bit,
   input wire logic i_out_tick,
   output logic [WORD_W-1:0] o_word
);

   localparam int LOG_OSR = $clog2(OSR);
   localparam int GROW = ORDER * LOG_OSR;
   localparam int ACC_W = GROW + 2;
   localparam int SHIFT = GROW - WORD_W + 1;

   if (OSR != (1 << LOG_OSR) || ORDER < 1 || PAD < 1 || SHIFT < 0)
   begin : g_bad_param
      $error("sadc_cic: unsupported parameter set");
   end

   logic signed [ACC_W-1:0] in_val;
   logic signed [ACC_W-1:0] integ_reg [ORDER];
   logic signed [ACC_W-1:0] comb_dly_reg [ORDER];
   logic signed [ACC_W-1:0] comb_val [ORDER+1];
   logic signed [ACC_W-1:0] scaled;
   logic over;
   logic [WORD_W-1:0] sat_word;
   logic [WORD_W-1:0] pad_mem [PAD];

   // ****************************************
   // integrators at the modulator rate
   // ****************************************
   // one bit maps to +1 / -1; integrators wrap on purpose, the combs undo it
   assign in_val = i_mod_bit ? ACC_W'(1) : {ACC_W{1'b1}};

   for (genvar k = 0; k < ORDER; k++)
   begin : g_integ
      logic signed [ACC_W-1:0] stage_in;
      if (k == 0)
      begin : g_first
         assign stage_in = in_val;
      end
      else
      begin : g_next
         assign stage_in = integ_reg[k-1];
      end
      always_ff @(posedge i_core_clk)
      begin
         if (!i_rst_b)
            integ_reg[k] <= '0;
         else if (i_clk_en && i_mod_tick)
            integ_reg[k] <= integ_reg[k] + stage_in;
      end
   end

   // ****************************************
   // combs at the sample rate
   // ****************************************
   assign comb_val[0] = integ_reg[ORDER-1];

   for (genvar k = 0; k < ORDER; k++)
   begin : g_comb
      assign comb_val[k+1] = comb_val[k] - comb_dly_reg[k];
      always_ff @(posedge i_core_clk)
      begin
         if (!i_rst_b)
            comb_dly_reg[k] <= '0;
         else if (i_clk_en && i_out_tick)
            comb_dly_reg[k] <= comb_val[k];
      end
   end

   // full scale is +/- OSR**ORDER; only the positive end needs clipping
   assign scaled = comb_val[ORDER] >>> SHIFT;
   assign over = scaled > $signed(ACC_W'((1 << (WORD_W - 1)) - 1));
   assign sat_word = over ? {1'b0, {(WORD_W-1){1'b1}}} : scaled[WORD_W-1:0];

   // ****************************************
   // output-rate delay line
   // ****************************************
   // pads the symmetric response so the total delay is a fixed whole number of frames
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         for (int i = 0; i < PAD; i++)
            pad_mem[i] <= '0;
      end
      else if (i_clk_en && i_out_tick)
      begin
         pad_mem[0] <= sat_word;
         for (int i = 1; i < PAD; i++)
            pad_mem[i] <= pad_mem[i-1];
      end
   end

   assign o_word = pad_mem[PAD-1];

endmodule : sadc_cic

// >>> sadc_top.sv
`timescale 1ns/10ps
`include "sadc_defs.svh"

module sadc_top #(
   parameter int WORD_W = `SADC_WORD_W,
   parameter int OSR = `SADC_MOD_OSR,
   parameter int DIV_256 = `SADC_DIV_256,
   parameter int DIV_384 = `SADC_DIV_384,
   parameter int GROUP_DELAY = `SADC_GROUP_DELAY_FS,
   parameter int CAL_FRAMES = `SADC_CAL_FRAMES,
   parameter int CAL_AVG_LOG2 = `SADC_CAL_AVG_LOG2
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire sadc_pkg::sadc_mode_t i_mode,
   input wire sadc_pkg::sadc_mod_bits_t i_mod,
   input wire sadc_pkg::sadc_slave_clk_t i_slave_clk,
   output sadc_pkg::sadc_ser_out_t o_ser,
   output logic o_clk_oe,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`SADC_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);

   localparam int CIC_ORDER = `SADC_CIC_ORDER;
   localparam int PAD = GROUP_DELAY - CIC_ORDER / 2;
   localparam int BIT_W = $clog2(OSR);
   localparam int SLOT = OSR / 2;
   localparam int CAL_W = $clog2(CAL_FRAMES + 1);
   localparam int SUM_W = WORD_W + CAL_AVG_LOG2;

   if (DIV_256 < 2 || DIV_384 < 2 || DIV_256 > 8 || DIV_384 > 8 || OSR != 4 * WORD_W ||
       OSR != (1 << BIT_W) || PAD < 1 || WORD_W > 32 || CAL_FRAMES <= (1 << CAL_AVG_LOG2))
   begin : g_bad_param
      $error("sadc_top: unsupported parameter set");
   end

   sadc_pkg::sadc_start_t start_reg;
   sadc_pkg::sadc_start_t start_next;
   sadc_pkg::sadc_cal_t cal_reg;
   logic [2:0] div_cnt_reg;
   logic [2:0] div_cnt_next;
   logic [BIT_W-1:0] bit_cnt_reg;
   logic [CAL_W-1:0] cal_cnt_reg;
   logic frame_prev_reg;
   logic bclk_prev_reg;
   logic [OSR-1:0] tx_shift_reg;
   logic [OSR-1:0] tx_shift_next;
   logic [WORD_W-1:0] word_reg [2];
   logic [WORD_W-1:0] raw_word [2];
   logic [WORD_W-1:0] out_word [2];
   logic ofs_en_reg;
   logic [31:0] prdata_reg;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [WORD_W-1:0] sat_sub(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
      logic [WORD_W:0] d;
      d = {a[WORD_W-1], a} - {b[WORD_W-1], b};
      if (d[WORD_W] != d[WORD_W-1])
         sat_sub = d[WORD_W] ? {1'b1, {(WORD_W-1){1'b0}}} : {1'b0, {(WORD_W-1){1'b1}}};
      else
         sat_sub = d[WORD_W-1:0];
   endfunction : sat_sub

   function automatic logic reg_known(input logic [`SADC_ADDR_W-1:0] a);
      reg_known = (a == `SADC_REG_CTRL) || (a == `SADC_REG_STATUS) ||
                  (a == `SADC_REG_LEFT) || (a == `SADC_REG_RIGHT);
   endfunction : reg_known

   // ****************************************
   // modulator clock divider and frame timing
   // ****************************************
   wire active = (start_reg == sadc_pkg::SADC_ST_RUN);
   wire run = i_clk_en && active;
   wire [2:0] div_last = i_mode.ratio_384 ? 3'(DIV_384 - 1) : 3'(DIV_256 - 1);
   wire [2:0] div_half = i_mode.ratio_384 ? 3'(DIV_384 / 2) : 3'(DIV_256 / 2);
   wire mod_tick = run && (div_cnt_reg == div_last);
   wire frame_tick = mod_tick && (bit_cnt_reg == BIT_W'(OSR - 1));
   wire bclk_int = (div_cnt_reg < div_half);

   assign div_cnt_next = mod_tick ? 3'h0 : div_cnt_reg + 3'h1;

   // both counters leave reset at zero so parts sharing clock and reset stay in step
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         div_cnt_reg <= 3'h0;
         bit_cnt_reg <= '0;
      end
      else if (run)
      begin
         div_cnt_reg <= div_cnt_next;
         if (mod_tick)
            bit_cnt_reg <= bit_cnt_reg + BIT_W'(1);
      end
   end

   // ****************************************
   // slave start gate
   // ****************************************
   wire frame_fall = frame_prev_reg && !i_slave_clk.channel_frame_clock;
   wire frame_rise = !frame_prev_reg && i_slave_clk.channel_frame_clock;
   wire bclk_fall = bclk_prev_reg && !i_slave_clk.bit_clock;
   wire bclk_rise = !bclk_prev_reg && i_slave_clk.bit_clock;
   // data moves on the edge opposite to the one the receiver reads on
   wire slave_shift = i_mode.read_edge_select ? bclk_fall : bclk_rise;

   always_comb
   begin
      start_next = start_reg;
      case (start_reg)
         sadc_pkg::SADC_ST_WAIT_FALL:
            if (!i_mode.slave_mode)
               start_next = sadc_pkg::SADC_ST_RUN;
            else if (frame_fall)
               start_next = sadc_pkg::SADC_ST_WAIT_RISE;
         sadc_pkg::SADC_ST_WAIT_RISE:
            if (!i_mode.slave_mode || frame_rise)
               start_next = sadc_pkg::SADC_ST_RUN;
         sadc_pkg::SADC_ST_RUN:
            start_next = sadc_pkg::SADC_ST_RUN;
         default:
            start_next = sadc_pkg::SADC_ST_WAIT_FALL;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         start_reg <= sadc_pkg::SADC_ST_WAIT_FALL;
         frame_prev_reg <= 1'b0;
         bclk_prev_reg <= 1'b0;
      end
      else if (i_clk_en)
      begin
         start_reg <= start_next;
         frame_prev_reg <= i_slave_clk.channel_frame_clock;
         bclk_prev_reg <= i_slave_clk.bit_clock;
      end
   end

   // ****************************************
   // decimation filters and offset calibration
   // ****************************************
   // counting frames from the divider means slave mode only counts after the gate
   wire cal_busy = (cal_reg == sadc_pkg::SADC_CAL_RUN);
   wire cal_last = cal_busy && (cal_cnt_reg == CAL_W'(CAL_FRAMES - 1));
   wire cal_window = cal_busy && (cal_cnt_reg >= CAL_W'(CAL_FRAMES - (1 << CAL_AVG_LOG2)));
   wire ctrl_wr = i_psel && i_penable && i_pwrite && i_clk_en && (i_paddr == `SADC_REG_CTRL);
   wire recal = ctrl_wr && i_pwdata[`SADC_CTRL_RECAL_BIT];

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b || recal)
      begin
         cal_reg <= sadc_pkg::SADC_CAL_RUN;
         cal_cnt_reg <= '0;
      end
      else if (frame_tick && cal_busy)
      begin
         cal_cnt_reg <= cal_cnt_reg + CAL_W'(1);
         if (cal_last)
            cal_reg <= sadc_pkg::SADC_CAL_DONE;
      end
   end

   for (genvar ch = 0; ch < 2; ch++)
   begin : g_chan
      logic signed [SUM_W-1:0] sum_reg;
      logic signed [SUM_W-1:0] sum_new;
      logic [WORD_W-1:0] ofs_reg;

      sadc_cic #(
         .ORDER(CIC_ORDER),
         .OSR(OSR),
         .WORD_W(WORD_W),
         .PAD(PAD)
      ) u_cic (
         .i_core_clk(i_core_clk),
         .i_rst_b(i_rst_b),
         .i_clk_en(i_clk_en),
         .i_mod_tick(mod_tick),
         .i_mod_bit(ch == 0 ? i_mod.left : i_mod.right),
         .i_out_tick(frame_tick),
         .o_word(raw_word[ch])
      );

      assign sum_new = sum_reg + SUM_W'($signed(raw_word[ch]));
      // output is muted while the offset is being learned
      assign out_word[ch] = cal_busy ? '0 : (ofs_en_reg ? sat_sub(raw_word[ch], ofs_reg) : raw_word[ch]);

      always_ff @(posedge i_core_clk)
      begin
         if (!i_rst_b || recal)
         begin
            sum_reg <= '0;
            if (!i_rst_b)
               ofs_reg <= '0;
         end
         else if (frame_tick && cal_window)
         begin
            sum_reg <= sum_new;
            if (cal_last)
               ofs_reg <= sum_new[SUM_W-1:CAL_AVG_LOG2];
         end
      end

      always_ff @(posedge i_core_clk)
      begin
         if (!i_rst_b)
            word_reg[ch] <= '0;
         else if (frame_tick)
            word_reg[ch] <= out_word[ch];
      end
   end

   // ****************************************
   // serial output
   // ****************************************
   // left slot first, each word left-justified in its half of the frame
   wire [OSR-1:0] tx_frame = {word_reg[0], {(SLOT-WORD_W){1'b0}}, word_reg[1], {(SLOT-WORD_W){1'b0}}};
   wire tx_load = i_mode.slave_mode ? (run && frame_rise) : frame_tick;
   wire tx_shift = i_mode.slave_mode ? (run && slave_shift) : mod_tick;

   assign tx_shift_next = tx_load ? tx_frame : {tx_shift_reg[OSR-2:0], 1'b0};

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         tx_shift_reg <= '0;
      else if (tx_load || tx_shift)
         tx_shift_reg <= tx_shift_next;
   end

   // clocks stay static until the core is running, and reset forces that state
   assign o_ser.serial_sample_output = tx_shift_reg[OSR-1];
   assign o_ser.bit_clock = (!i_mode.slave_mode && active && bclk_int) ^ i_mode.read_edge_select;
   assign o_ser.channel_frame_clock = !i_mode.slave_mode && active && !bit_cnt_reg[BIT_W-1];
   assign o_clk_oe = !i_mode.slave_mode;

   // ****************************************
   // register bus
   // ****************************************
   wire [31:0] status_word = {29'h0, cal_reg == sadc_pkg::SADC_CAL_DONE, cal_busy, active};
   wire [31:0] rd_mux =
      (i_paddr == `SADC_REG_CTRL) ? {30'h0, ofs_en_reg, 1'b0} :
      (i_paddr == `SADC_REG_STATUS) ? status_word :
      (i_paddr == `SADC_REG_LEFT) ? {{(32-WORD_W){1'b0}}, word_reg[0]} :
      (i_paddr == `SADC_REG_RIGHT) ? {{(32-WORD_W){1'b0}}, word_reg[1]} : 32'h0;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         ofs_en_reg <= `SADC_CTRL_OFS_EN_RESET;
         prdata_reg <= 32'h0;
      end
      else if (i_clk_en)
      begin
         if (ctrl_wr)
            ofs_en_reg <= i_pwdata[`SADC_CTRL_OFS_EN_BIT];
         if (i_psel && !i_penable)
            prdata_reg <= rd_mux;
      end
   end

   // a frozen core cannot answer, so the bus waits with it
   assign o_pready = i_clk_en;
   assign o_pslverr = i_psel && i_penable && !reg_known(i_paddr);
   assign o_prdata = prdata_reg;

endmodule : sadc_top

// >>> sadc_top_sva.sv
`timescale 1ns/10ps
`include "sadc_defs.svh"
// ****
// port checker
// ****
module sadc_chk #(
   parameter int CAL_FRAMES = 8192
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire sadc_pkg::sadc_mode_t i_mode,
   input wire sadc_pkg::sadc_slave_clk_t i_slave_clk,
   input wire sadc_pkg::sadc_ser_out_t o_ser,
   input wire logic o_clk_oe,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [`SADC_ADDR_W-1:0] i_paddr,
   input wire logic o_pready,
   input wire logic o_pslverr
);
   logic [9:0] cyc;
   logic [6:0] nb;
   logic seen;
   logic [1:0] gate;
   int nfr;
   wire fc = o_ser.channel_frame_clock;
   wire bc = o_ser.bit_clock;
   wire mst = !i_mode.slave_mode;
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);
   // a frozen clock enable breaks the period count, so timing is judged only on clean frames
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
      begin
         seen <= 1'b0;
         nfr <= 0;
      end
      else if ($rose(fc))
      begin
         seen <= i_clk_en;
         nfr <= nfr + 1;
      end
      else if (!i_clk_en)
         seen <= 1'b0;
   end
   always_ff @(posedge i_core_clk)
   begin
      cyc <= $rose(fc) ? 10'h000 : cyc + 10'h001;
      nb <= $rose(fc) ? 7'h00 : nb + 7'($rose(bc));
   end
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_b)
         gate <= 2'h0;
      else if (gate == 2'h0 && $fell(i_slave_clk.channel_frame_clock))
         gate <= 2'h1;
      else if (gate == 2'h1 && $rose(i_slave_clk.channel_frame_clock))
         gate <= 2'h2;
   end
   reset_quiet_a: assert property (disable iff (1'b0) !i_rst_b && $past(!i_rst_b) |-> o_ser == {i_mode.read_edge_select, 2'h0})
      else $error("outputs not quiet under reset");
   clk_drive_a: assert property (o_clk_oe == mst)
      else $error("clock drive enable wrong for mode");
   frame_len_a: assert property (mst && seen && $rose(fc) |-> cyc == (i_mode.ratio_384 ? 10'h17F : 10'h0FF))
      else $error("frame period wrong");
   left_half_a: assert property (mst && seen && $fell(fc) |-> cyc == (i_mode.ratio_384 ? 10'h0BF : 10'h07F))
      else $error("left slot length wrong");
   frame_bits_a: assert property (mst && seen && $rose(fc) |-> 7'(nb + 7'($rose(bc))) == 7'h40)
      else $error("bit clocks per frame wrong");
   slave_hold_a: assert property (!mst && gate != 2'h2 |-> !o_ser.serial_sample_output)
      else $error("slave output moved before start");
   cal_mute_a: assert property (mst && nfr + 1 < CAL_FRAMES |-> !o_ser.serial_sample_output)
      else $error("data sent during calibration");
   bad_addr_a: assert property (i_psel && i_penable && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 8'h0C))
      else $error("error response wrong");
   ready_en_a: assert property (o_pready == i_clk_en)
      else $error("ready does not follow clock enable");
   cover property (mst && seen && $rose(fc) && i_mode.ratio_384);
   cover property (!mst && gate == 2'h2);
   cover property (o_pslverr);
endmodule : sadc_chk

bind sadc_top sadc_chk #(.CAL_FRAMES(CAL_FRAMES)) u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
   .i_clk_en(i_clk_en), .i_mode(i_mode), .i_slave_clk(i_slave_clk), .o_ser(o_ser), .o_clk_oe(o_clk_oe),
   .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr));

// >>> sadc_rx_model.sv
`timescale 1ns/10ps
// ****
// serial audio receiver
// ****
module sadc_rx_model (
   input wire logic i_core_clk,
   input wire logic i_en,
   input wire logic i_slave,
   input wire logic i_read_edge,
   input wire sadc_pkg::sadc_ser_out_t i_ser,
   output sadc_pkg::sadc_slave_clk_t o_clk,
   output logic [31:0] o_left,
   output logic [31:0] o_right
);
   logic [7:0] cnt = 8'h00;
   logic bc_q = 1'b0;
   logic fc_q = 1'b0;
   logic [31:0] sh = 32'h0;
   // both clocks come from one counter on the master clock and stand still until enabled
   assign o_clk.bit_clock = cnt[1];
   // frame clock idles high, so the start sequence seen is high, low, then high
   assign o_clk.channel_frame_clock = !cnt[7];
   wire bc = i_slave ? o_clk.bit_clock : i_ser.bit_clock;
   wire fc = i_slave ? o_clk.channel_frame_clock : i_ser.channel_frame_clock;
   always @(posedge i_core_clk)
   begin
      cnt <= i_en ? cnt + 8'h01 : cnt;
      bc_q <= bc;
      fc_q <= fc;
      if (bc != bc_q && bc == i_read_edge)
         sh <= {sh[30:0], i_ser.serial_sample_output};
      if (fc_q && !fc)
         o_left <= sh;
      if (!fc_q && fc)
         o_right <= sh;
   end
endmodule : sadc_rx_model

// >>> tb_stereo_adc_decimator_control.sv
`timescale 1ns/10ps
`include "sadc_defs.svh"
module tb_stereo_adc_decimator_control;
   logic core_clk = 1'b0;
   logic rst_b;
   logic clk_en;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic clk_oe;
   logic rx_en;
   logic lsel;
   logic tgl = 1'b0;
   logic [2:0] ph = 3'h0;
   logic [31:0] rx_left;
   logic [31:0] rx_right;
   sadc_pkg::sadc_mode_t mode;
   sadc_pkg::sadc_mod_bits_t modb = '0;
   sadc_pkg::sadc_slave_clk_t sclk;
   sadc_pkg::sadc_ser_out_t ser;
   int miscompares = 0;
   int n_tests = 0;
   sadc_top #(.CAL_FRAMES(20), .CAL_AVG_LOG2(4)) dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
      .i_mode(mode), .i_mod(modb), .i_slave_clk(sclk), .o_ser(ser), .o_clk_oe(clk_oe), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr));
   sadc_rx_model rx (.i_core_clk(core_clk), .i_en(rx_en), .i_slave(mode.slave_mode),
      .i_read_edge(mode.read_edge_select), .i_ser(ser), .o_clk(sclk), .o_left(rx_left), .o_right(rx_right));
   always #5 core_clk = !core_clk;
   // ****
   // stimulus helpers
   // ****
   // the square wave flips once per modulator tick, so its mean is exactly zero
   always @(posedge core_clk)
   begin
      ph <= (ph == (mode.ratio_384 ? 3'h5 : 3'h3)) ? 3'h0 : ph + 3'h1;
      tgl <= (ph == 3'h0) ? !tgl : tgl;
      modb <= '{left: lsel | tgl, right: tgl};
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never re-drives the strobes in this step
      @(posedge core_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err, input string what);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(what, q, exp);
      chk("error flag", e, err);
   endtask : rd
   task automatic do_reset(input sadc_pkg::sadc_mode_t m);
      rst_b <= 1'b0;
      mode <= m;
      rx_en <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk("pins in reset", {29'h0, ser}, {29'h0, m.read_edge_select, 2'h0});
      chk("clock drive", clk_oe, !m.slave_mode);
      // released clear of the sampling edge, as a shared reset must be
      rst_b <= 1'b1;
      @(posedge core_clk);
   endtask : do_reset
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial
   begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      conclude();
   end
   // ****
   // tests
   // ****
   initial
   begin
      time t0;
      logic [31:0] q;
      logic e;
      rst_b = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx_en = 1'b0;
      lsel = 1'b0;
      mode = 3'h1;
      do_reset(3'h1);
      rd(`SADC_REG_CTRL, 32'h2, 1'b0, "ctrl reset");
      rd(`SADC_REG_STATUS, 32'h3, 1'b0, "status calibrating");
      rd(8'h10, 32'h0, 1'b1, "unmapped read");
      rd(`SADC_REG_LEFT, 32'h0, 1'b0, "left in calibration");
      repeat (24 * 256) @(posedge core_clk);
      rd(`SADC_REG_STATUS, 32'h5, 1'b0, "status calibrated");
      lsel <= 1'b1;
      repeat (32 * 256) @(posedge core_clk);
      rd(`SADC_REG_LEFT, 32'h0, 1'b0, "left inside delay");
      repeat (8 * 256) @(posedge core_clk);
      apb(1'b1, `SADC_REG_LEFT, 32'h0, q, e);
      rd(`SADC_REG_LEFT, 32'h7FFF, 1'b0, "left full scale");
      rd(`SADC_REG_RIGHT, 32'h0, 1'b0, "right zero");
      chk("serial left slot", rx_left, 32'h7FFF0000);
      chk("serial right slot", rx_right, 32'h0);
      apb(1'b1, `SADC_REG_CTRL, 32'h1, q, e);
      rd(`SADC_REG_CTRL, 32'h0, 1'b0, "ctrl offset off");
      rd(`SADC_REG_STATUS, 32'h3, 1'b0, "status recalibrating");
      $display("test master run done");
      do_reset(3'h0);
      rd(`SADC_REG_LEFT, 32'h0, 1'b0, "left cleared");
      rd(`SADC_REG_STATUS, 32'h3, 1'b0, "status restarted");
      $display("test mid-run reset done");
      for (int r = 0; r < 2; r++)
      begin
         do_reset({r[0], 2'h1});
         t0 = $time;
         @(posedge ser.channel_frame_clock);
         chk("start cycle", 32'(($time - t0) / 10), 32'h0);
         t0 = $time;
         @(negedge ser.channel_frame_clock);
         chk("left slot cycles", 32'(($time - t0) / 10), r ? 32'hC0 : 32'h80);
         @(posedge ser.channel_frame_clock);
         chk("frame cycles", 32'(($time - t0) / 10), r ? 32'h180 : 32'h100);
      end
      $display("test clock ratios done");
      lsel <= 1'b0;
      do_reset(3'h3);
      clk_en <= 1'b0;
      @(posedge core_clk);
      chk("ready held", pready, 1'b0);
      clk_en <= 1'b1;
      repeat (50) @(posedge core_clk);
      rd(`SADC_REG_STATUS, 32'h2, 1'b0, "status before start");
      rx_en <= 1'b1;
      repeat (300) @(posedge core_clk);
      rd(`SADC_REG_STATUS, 32'h3, 1'b0, "status after start");
      repeat (5400) @(posedge core_clk);
      rd(`SADC_REG_STATUS, 32'h5, 1'b0, "slave calibrated");
      $display("test slave start done");
      conclude();
   end
endmodule : tb_stereo_adc_decimator_control
